// ---- design/jtag_tap_instruction_logic.sv ----
`timescale 1ns/1ps
`default_nettype none


module jtag_tap_instruction_logic
  import tap_pkg::*;
(
  // System clock domain
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  // Test port, clocked by tck
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  // Memory core and pins
  input  wire logic [BSR_LEN-1:0] core_out,
  input  wire logic [BSR_LEN-1:0] core_oe,
  input  wire logic [BSR_LEN-1:0] pad_sense,
  output logic      [BSR_LEN-1:0] pad_out,
  output logic      [BSR_LEN-1:0] pad_oe
);

  // ==========================================================
  // Decoding helpers
  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    tap_state_t n;
    n = s;
    unique case (s)
      TLR:    n = m ? TLR    : RTI;
      RTI:    n = m ? SEL_DR : RTI;
      SEL_DR: n = m ? SEL_IR : CAP_DR;
      CAP_DR: n = m ? EX1_DR : SH_DR;
      SH_DR:  n = m ? EX1_DR : SH_DR;
      EX1_DR: n = m ? UPD_DR : PAU_DR;
      PAU_DR: n = m ? EX2_DR : PAU_DR;
      EX2_DR: n = m ? UPD_DR : SH_DR;
      UPD_DR: n = m ? SEL_DR : RTI;
      SEL_IR: n = m ? TLR    : CAP_IR;
      CAP_IR: n = m ? EX1_IR : SH_IR;
      SH_IR:  n = m ? EX1_IR : SH_IR;
      EX1_IR: n = m ? UPD_IR : PAU_IR;
      PAU_IR: n = m ? EX2_IR : PAU_IR;
      EX2_IR: n = m ? UPD_IR : SH_IR;
      UPD_IR: n = m ? SEL_DR : RTI;
    endcase
    return n;
  endfunction

  function automatic scan_path_t path_of(input logic [IR_W-1:0] op);
    scan_path_t p;
    unique case (op)
      OP_IDCODE:            p = PATH_ID;
      OP_EXTEST, OP_SAMPLE: p = PATH_BSR;
      OP_CLAMP, OP_HIGHZ:   p = PATH_BYP;
      OP_BYPASS:            p = PATH_BYP;
      default:              p = PATH_BYP;
    endcase
    return p;
  endfunction

  function automatic drive_mode_t mode_of(input logic [IR_W-1:0] op);
    drive_mode_t d;
    unique case (op)
      OP_EXTEST, OP_CLAMP: d = MODE_DRIVE;
      OP_HIGHZ:            d = MODE_HIGHZ;
      default:             d = MODE_FUNC;
    endcase
    return d;
  endfunction

  // ==========================================================
  // Test clock domain state
  typedef struct packed {
    logic               rst_s1;
    logic               rst_s2;
    logic               en_s1;
    logic               en_s2;
    logic [BSR_LEN-1:0] sense_s1;
    logic [BSR_LEN-1:0] sense_s2;
    logic               ack_s1;
    logic               ack_s2;
    tap_state_t         tap;
    logic [IR_W-1:0]    ir;
    logic [IR_W-1:0]    ir_sh;
    logic [ID_W-1:0]    id_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic               byp;
    drive_mode_t        hold_mode;
    logic [BSR_LEN-1:0] hold_vec;
    logic               req_tgl;
  } tap_regs_t;

  tap_regs_t  st_ff;
  tap_regs_t  nxt_st;
  scan_path_t cur_path;
  drive_mode_t cur_mode;
  logic       nxt_tdo;
  logic       nxt_tdo_oe;
  logic       tdo_ff;
  logic       tdo_oe_ff;

  pad_xfer_if xfer ();

  assign cur_path = path_of(st_ff.ir);
  assign cur_mode = mode_of(st_ff.ir);

  always_comb begin
    nxt_st = st_ff;
    // Reset and enable synchronisers run regardless of the enable so a frozen block still sees reset
    nxt_st.rst_s1   = sys_rst;
    nxt_st.rst_s2   = st_ff.rst_s1;
    nxt_st.en_s1    = clk_en;
    nxt_st.en_s2    = st_ff.en_s1;
    if (st_ff.en_s2) begin
      // Pins are asynchronous to tck; a pin moving in the window may capture either way
      nxt_st.sense_s1 = pad_sense;
      nxt_st.sense_s2 = st_ff.sense_s1;
      nxt_st.ack_s1   = xfer.ack_tgl;
      nxt_st.ack_s2   = st_ff.ack_s1;
      nxt_st.tap      = tap_next(st_ff.tap, tms);

      unique case (st_ff.tap)
        TLR: begin
          nxt_st.ir = OP_IDCODE;
        end
        CAP_IR: begin
          nxt_st.ir_sh = IR_CAPTURE;
        end
        SH_IR: begin
          nxt_st.ir_sh = {tdi, st_ff.ir_sh[IR_W-1:1]};
        end
        UPD_IR: begin
          nxt_st.ir = st_ff.ir_sh;
        end
        CAP_DR: begin
          unique case (cur_path)
            PATH_ID:  nxt_st.id_sh  = ID_WORD;
            PATH_BSR: nxt_st.bsr_sh = st_ff.sense_s2;
            PATH_BYP: nxt_st.byp    = BYP_CAPTURE;
            default:  nxt_st.byp    = BYP_CAPTURE;
          endcase
        end
        SH_DR: begin
          unique case (cur_path)
            PATH_ID:  nxt_st.id_sh  = {tdi, st_ff.id_sh[ID_W-1:1]};
            PATH_BSR: nxt_st.bsr_sh = {tdi, st_ff.bsr_sh[BSR_LEN-1:1]};
            PATH_BYP: nxt_st.byp    = tdi;
            default:  nxt_st.byp    = tdi;
          endcase
        end
        UPD_DR: begin
          // Preload and EXTEST both latch the shifted vector for the pins
          if (cur_path == PATH_BSR) begin
            nxt_st.bsr_upd = st_ff.bsr_sh;
          end
        end
        default: begin
          nxt_st.tap = tap_next(st_ff.tap, tms);
        end
      endcase

      // Launch a new pin word only once the last one has been acknowledged
      if ((st_ff.ack_s2 == st_ff.req_tgl) &&
          ((cur_mode != st_ff.hold_mode) || (st_ff.bsr_upd != st_ff.hold_vec))) begin
        nxt_st.hold_mode = cur_mode;
        nxt_st.hold_vec  = st_ff.bsr_upd;
        nxt_st.req_tgl   = ~st_ff.req_tgl;
      end
    end

    if (st_ff.rst_s2) begin
      nxt_st.tap       = TLR;
      nxt_st.ir        = OP_IDCODE;
      nxt_st.ir_sh     = '0;
      nxt_st.id_sh     = '0;
      nxt_st.bsr_sh    = '0;
      nxt_st.bsr_upd   = '0;
      nxt_st.byp       = BYP_CAPTURE;
      nxt_st.hold_mode = MODE_FUNC;
      nxt_st.hold_vec  = '0;
      nxt_st.req_tgl   = 1'b0;
      nxt_st.ack_s1    = 1'b0;
      nxt_st.ack_s2    = 1'b0;
    end
  end

  always_ff @(posedge tck) begin
    st_ff <= nxt_st;
  end

  // ==========================================================
  // Serial output, launched on the falling test clock edge
  always_comb begin
    nxt_tdo_oe = (st_ff.tap == SH_IR) || (st_ff.tap == SH_DR);
    nxt_tdo    = st_ff.byp;
    if (st_ff.tap == SH_IR) begin
      nxt_tdo = st_ff.ir_sh[0];
    end else begin
      unique case (cur_path)
        PATH_ID:  nxt_tdo = st_ff.id_sh[0];
        PATH_BSR: nxt_tdo = st_ff.bsr_sh[0];
        PATH_BYP: nxt_tdo = st_ff.byp;
        default:  nxt_tdo = st_ff.byp;
      endcase
    end
  end

  // Kept apart from the state record because it runs on the opposite edge
  always_ff @(negedge tck) begin
    if (st_ff.rst_s2) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (st_ff.en_s2) begin
      tdo_ff    <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign tdo    = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  assign xfer.vec     = st_ff.hold_vec;
  assign xfer.mode    = st_ff.hold_mode;
  assign xfer.req_tgl = st_ff.req_tgl;

  // ==========================================================
  // Pin drive in the memory clock domain
  pad_drive_stage u_pad_drive (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .xfer     (xfer.land),
    .core_out (core_out),
    .core_oe  (core_oe),
    .pad_out  (pad_out),
    .pad_oe   (pad_oe)
  );

endmodule // jtag_tap_instruction_logic

`default_nettype wire

// ---- design/tap_pkg.sv ----
package tap_pkg;

  // ==========================================================
  // Register sizes
  localparam int IR_W    = 8;
  localparam int ID_W    = 32;
  localparam int BSR_LEN = 135;

  // ==========================================================
  // Instruction codes
  localparam logic [IR_W-1:0] OP_EXTEST  = 8'h00;
  localparam logic [IR_W-1:0] OP_IDCODE  = 8'h21;
  localparam logic [IR_W-1:0] OP_SAMPLE  = 8'h05;
  localparam logic [IR_W-1:0] OP_CLAMP   = 8'h07;
  localparam logic [IR_W-1:0] OP_HIGHZ   = 8'h03;
  localparam logic [IR_W-1:0] OP_BYPASS  = 8'hFF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;

  // Value is arbitrary; bit 0 marks the presence of the register
  localparam logic [ID_W-1:0] ID_WORD = 32'h0A5C_3E01;

  // Capture value of the single-bit bypass register
  localparam logic BYP_CAPTURE = 1'b0;

  // ==========================================================
  // Timing of the test clock and the pin capture window
  localparam int CLK_PERIOD_PS              = 4000;
  localparam int TEST_CLOCK_PERIOD_MIN_NS   = 20;
  localparam int CAPTURE_SETUP_TIME_NS      = 5;
  localparam int CAPTURE_HOLD_TIME_NS       = 5;
  localparam int TEST_CLOCK_PERIOD_MIN_CYC  =
    (TEST_CLOCK_PERIOD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAPTURE_WINDOW_CYC         =
    ((CAPTURE_SETUP_TIME_NS + CAPTURE_HOLD_TIME_NS) * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef enum logic [1:0] {PATH_BYP, PATH_ID, PATH_BSR} scan_path_t;

  typedef enum logic [1:0] {MODE_FUNC, MODE_DRIVE, MODE_HIGHZ} drive_mode_t;

endpackage

// ---- design/pad_xfer_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Carries the pin-drive word from the test clock domain to the memory clock domain
interface pad_xfer_if;
  import tap_pkg::*;
  logic [BSR_LEN-1:0] vec;
  drive_mode_t        mode;
  logic               req_tgl;
  logic               ack_tgl;

  modport launch (output vec, output mode, output req_tgl, input ack_tgl);
  modport land   (input vec, input mode, input req_tgl, output ack_tgl);
endinterface

`default_nettype wire

// ---- design/pad_drive_stage.sv ----
`timescale 1ns/1ps
`default_nettype none

module pad_drive_stage
  import tap_pkg::*;
(
  // System
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  // Crossing from the test port
  pad_xfer_if.land                xfer,
  // Memory core and pins
  input  wire logic [BSR_LEN-1:0] core_out,
  input  wire logic [BSR_LEN-1:0] core_oe,
  output logic      [BSR_LEN-1:0] pad_out,
  output logic      [BSR_LEN-1:0] pad_oe
);

  typedef struct packed {
    logic               req_s1;
    logic               req_s2;
    logic               req_s3;
    logic               ack;
    drive_mode_t        mode;
    logic [BSR_LEN-1:0] vec;
    logic [BSR_LEN-1:0] out;
    logic [BSR_LEN-1:0] oe;
  } pad_state_t;

  pad_state_t st_ff;
  pad_state_t nxt_st;

  // ==========================================================
  // Handshake landing and pin multiplexing
  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.req_s1 = xfer.req_tgl;
      nxt_st.req_s2 = st_ff.req_s1;
      nxt_st.req_s3 = st_ff.req_s2;
      // Word is stable while the toggle differs from the returned ack
      if (st_ff.req_s2 != st_ff.req_s3) begin
        nxt_st.mode = xfer.mode;
        nxt_st.vec  = xfer.vec;
        nxt_st.ack  = st_ff.req_s2;
      end
      unique case (st_ff.mode)
        MODE_FUNC: begin
          nxt_st.out = core_out;
          nxt_st.oe  = core_oe;
        end
        MODE_DRIVE: begin
          nxt_st.out = st_ff.vec;
          nxt_st.oe  = '1;
        end
        MODE_HIGHZ: begin
          nxt_st.out = '0;
          nxt_st.oe  = '0;
        end
        default: begin
          nxt_st.out = core_out;
          nxt_st.oe  = core_oe;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign xfer.ack_tgl = st_ff.ack;
  assign pad_out      = st_ff.out;
  assign pad_oe       = st_ff.oe;

endmodule // pad_drive_stage

`default_nettype wire

// ---- verification/jtag_tap_instruction_logic_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module jtag_tap_instruction_logic_asserts
  import tap_pkg::*;
(
  // Clock and reset
  input wire logic               clock,
  input wire logic               sys_rst,
  // Test port
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tdo,
  input wire logic               tdo_oe,
  // Pins
  input wire logic [BSR_LEN-1:0] core_out,
  input wire logic [BSR_LEN-1:0] core_oe,
  input wire logic [BSR_LEN-1:0] pad_out,
  input wire logic [BSR_LEN-1:0] pad_oe
);
  // ==========
  // Pin side
  a_oe_uniform: assert property (@(posedge clock) disable iff (sys_rst)
    pad_oe == '1 || pad_oe == '0 || pad_oe == $past(core_oe)) else $error("bad pad enables");
  a_hiz_zero: assert property (@(posedge clock) disable iff (sys_rst)
    pad_oe == '0 && $past(core_oe) != '0 |-> pad_out == '0) else $error("floated pin driven");
  a_func_follow: assert property (@(posedge clock) disable iff (sys_rst)
    pad_oe == $past(core_oe) && pad_oe != '1 && pad_oe != '0 |-> pad_out == $past(core_out))
    else $error("pins not functional");
  // ==========
  // Test port: outputs move only on a falling test clock, and the enable follows the shift states
  a_tdo_fall: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(tdo) |-> $fell(tck)) else $error("tdo moved off the falling edge");
  a_tdoe_fall: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(tdo_oe) |-> $fell(tck)) else $error("tdo enable moved off the falling edge");
  a_oe_capture: assert property (@(posedge tck) disable iff (sys_rst)
    $rose(tdo_oe) |-> !$past(tms) && !$past(tms, 2)) else $error("shift without capture");
  a_oe_exit: assert property (@(posedge tck) disable iff (sys_rst)
    $past(tdo_oe) && $past(tms) |-> !tdo_oe) else $error("tdo enable held past shift");
  a_tlr_quiet: assert property (@(posedge tck) disable iff (sys_rst)
    tms [*5] |-> !tdo_oe) else $error("tdo enabled in reset walk");
endmodule // jtag_tap_instruction_logic_asserts

bind jtag_tap_instruction_logic jtag_tap_instruction_logic_asserts chk_u (
  .clock, .sys_rst, .tck, .tms, .tdo, .tdo_oe, .core_out, .core_oe, .pad_out, .pad_oe);

`default_nettype wire

// ---- verification/tap_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module tap_ctrl_model
  import tap_pkg::*;
(
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // ==========
  // Clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // 30 ns period keeps above the minimum test clock period
  task automatic pulse(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #15 tck = 1'b1;
    o = tdo;
    #15 tck = 1'b0;
  endtask

  // Idle tdi toggles so a stale value never looks like data
  task automatic to_reset(input int n);
    logic o;
    for (int i = 0; i < n; i++) pulse(1'b1, ~tdi, o);
    pulse(1'b0, ~tdi, o);
  endtask

  // From idle: capture, shift n bits LSB first, update, idle
  task automatic scan(input logic is_ir, input int n, input logic [BSR_LEN-1:0] din,
                      output logic [BSR_LEN-1:0] dout);
    logic o;
    dout = '0;
    #7.3;
    pulse(1'b1, ~tdi, o);
    if (is_ir) pulse(1'b1, ~tdi, o);
    pulse(1'b0, ~tdi, o);
    pulse(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], o);
      dout[i] = o;
    end
    pulse(1'b1, ~tdi, o);
    pulse(1'b0, ~tdi, o);
    pulse(1'b0, ~tdi, o);
  endtask
endmodule // tap_ctrl_model

`default_nettype wire

// ---- verification/jtag_tap_instruction_logic_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module jtag_tap_instruction_logic_tb_top import tap_pkg::*;;
  localparam logic [BSR_LEN-1:0] CORE_VAL = {27{5'h13}};
  localparam logic [BSR_LEN-1:0] CORE_EN  = {27{5'h0A}};
  localparam logic [BSR_LEN-1:0] SENSE_A  = {27{5'h16}};
  localparam logic [BSR_LEN-1:0] SENSE_B  = {27{5'h09}};
  localparam logic [BSR_LEN-1:0] VEC_A    = {45{3'h5}};
  localparam logic [BSR_LEN-1:0] VEC_B    = {45{3'h2}};
  localparam logic [IR_W-1:0]    OPS [4]  = '{OP_CLAMP, OP_HIGHZ, OP_BYPASS, 8'h5A};
  localparam logic [BSR_LEN-1:0] EXP_OE [4] = '{'1, '0, CORE_EN, CORE_EN};
  localparam logic [BSR_LEN-1:0] EXP_PO [4] = '{VEC_B, '0, CORE_VAL, CORE_VAL};

  logic clock, sys_rst, clk_en, tck, tms, tdi, tdo, tdo_oe;
  logic [BSR_LEN-1:0] core_out, core_oe, pad_sense, pad_out, pad_oe, dout;
  int fail_count, n_checks;

  jtag_tap_instruction_logic dut_u (.clock, .sys_rst, .clk_en, .tck, .tms, .tdi, .tdo,
    .tdo_oe, .core_out, .core_oe, .pad_sense, .pad_out, .pad_oe);
  tap_ctrl_model partner_u (.tck, .tms, .tdi, .tdo, .tdo_oe);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========
  // Checking and closing
  task automatic chk(input logic [BSR_LEN-1:0] got, input logic [BSR_LEN-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Pin updates cross domains: 2 test clocks plus 5 clocks covers the landing
  task automatic load_ir(input logic [IR_W-1:0] op);
    partner_u.scan(1'b1, IR_W, BSR_LEN'(op), dout);
    chk(dout, BSR_LEN'(IR_CAPTURE));
    repeat (20) @(posedge clock);
  endtask

  // ==========
  // Scenarios
  task automatic t_idcode;
    partner_u.scan(1'b0, ID_W, VEC_A, dout);
    chk(dout, BSR_LEN'(ID_WORD));
    chk(BSR_LEN'(tdo_oe), '0);
  endtask

  task automatic t_sample;
    // Sense pins held still, so no captured clock pin needs to be ignored
    @(posedge clock) pad_sense <= SENSE_A;
    load_ir(OP_SAMPLE);
    partner_u.scan(1'b0, BSR_LEN, VEC_A, dout);
    chk(dout, SENSE_A);
    repeat (20) @(posedge clock);
    chk(pad_oe, CORE_EN);
    chk(pad_out, CORE_VAL);
  endtask

  // Preload was made under sample, so the first vector is VEC_A
  task automatic t_extest;
    @(posedge clock) pad_sense <= SENSE_B;
    load_ir(OP_EXTEST);
    chk(pad_oe, '1);
    chk(pad_out, VEC_A);
    partner_u.scan(1'b0, BSR_LEN, VEC_B, dout);
    chk(dout, SENSE_B);
    repeat (20) @(posedge clock);
    chk(pad_out, VEC_B);
  endtask

  task automatic t_bypass_ops;
    for (int i = 0; i < 4; i++) begin
      load_ir(OPS[i]);
      chk(pad_oe, EXP_OE[i]);
      chk(pad_out, EXP_PO[i]);
      partner_u.scan(1'b0, 2, BSR_LEN'(1), dout);
      chk(dout, {133'h0, 1'b1, BYP_CAPTURE});
    end
  endtask

  task automatic t_reset_ir;
    load_ir(OP_IDCODE);
    t_idcode();
    load_ir(OP_BYPASS);
    partner_u.to_reset(5);
    t_idcode();
  endtask

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    core_out = CORE_VAL;
    core_oe = CORE_EN;
    pad_sense = SENSE_A;
    fail_count = 0;
    n_checks = 0;
    partner_u.to_reset(6);
    @(posedge clock) sys_rst <= 1'b0;
    partner_u.to_reset(5);
    t_idcode();
    t_sample();
    t_extest();
    t_bypass_ops();
    t_reset_ir();
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    finish_test();
  end
endmodule // jtag_tap_instruction_logic_tb_top

`default_nettype wire
